//--- design/mif_pkg.sv
// Purpose: Shared constants and types for the metering interrupt flag block
// Assumes: Classic Wishbone slave, 32-bit data, word-aligned registers
// Notes:   Register offsets are word indices; byte address is four times the index
package mif_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] MIF_IDX_ENABLE     = 8'h0a;
  localparam logic [7:0] MIF_IDX_FLAGS      = 8'h0b;
  localparam logic [7:0] MIF_IDX_FLAGS_RC   = 8'h0c;
  localparam logic [7:0] MIF_IDX_SW_RESET   = 8'h10;
  localparam int         MIF_ADDR_W         = 8;

  // ==========================================================================
  // Flag bit positions
  localparam int MIF_BIT_ACTIVE_HALF   = 0;
  localparam int MIF_BIT_DIP           = 1;
  localparam int MIF_BIT_CYCLE_DONE    = 2;
  localparam int MIF_BIT_SAMPLE_READY  = 3;
  localparam int MIF_BIT_ZERO_CROSS    = 4;
  localparam int MIF_BIT_TEMP_DONE     = 5;
  localparam int MIF_BIT_RESET_DONE    = 6;
  localparam int MIF_BIT_ACTIVE_OVF    = 7;
  localparam int MIF_BIT_VPEAK         = 8;
  localparam int MIF_BIT_IPEAK         = 9;
  localparam int MIF_BIT_APPARENT_HALF = 10;
  localparam int MIF_BIT_APPARENT_OVF  = 11;
  localparam int MIF_BIT_CROSS_TIMEOUT = 12;
  localparam int MIF_BIT_POWER_POS     = 13;
  localparam int MIF_BIT_POWER_NEG     = 14;
  localparam int MIF_FLAG_W            = 16;

  // ==========================================================================
  // Reset values and masks
  localparam logic [15:0] MIF_ENABLE_RST  = 16'h0000;
  localparam logic [15:0] MIF_FLAGS_RST   = 16'h0000;
  localparam logic [15:0] MIF_IMPL_MASK   = 16'h7fff;
  localparam logic [15:0] MIF_IRQ_MASK    = 16'h7fbf;
  localparam logic [1:0]  MIF_INIT_CYCLES = 2'h2;

  // ==========================================================================
  // Types
  typedef logic [15:0] mif_flags_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } mif_wb_req_t;

  typedef enum logic [1:0] {
    MIF_ST_INIT = 2'b00,
    MIF_ST_RUN  = 2'b01,
    MIF_ST_ACK  = 2'b11
  } mif_state_t;

endpackage

//--- design/mif_top.sv
// Purpose: Interrupt status, read-clear status and enable mask of a metering device
// Assumes: Event inputs are one-cycle pulses on ref_clk_i; host on classic Wishbone
// Notes:   Interrupt request pin is open drain, modelled as output plus enable
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps

module mif_top (
  input  wire logic        ref_clk_i,                   // 20 MHz clock
  input  wire logic        rst_n_i,                     // Async reset, active low
  input  wire logic        wb_cyc_i,                    // Wishbone cycle
  input  wire logic        wb_stb_i,                    // Wishbone strobe
  input  wire logic        wb_we_i,                     // Wishbone write enable
  input  wire logic [3:0]  wb_sel_i,                    // Wishbone byte selects
  input  wire logic [9:0]  wb_adr_i,                    // Wishbone byte address
  input  wire logic [31:0] wb_dat_i,                    // Wishbone write data
  output logic      [31:0] wb_dat_o,                    // Wishbone read data
  output logic             wb_ack_o,                    // Wishbone acknowledge
  input  wire logic        active_energy_half_full_i,   // Event pulse
  input  wire logic        line_voltage_dip_i,          // Event pulse
  input  wire logic        line_cycle_accum_done_i,     // Event pulse
  input  wire logic        waveform_sample_ready_i,     // Event pulse
  input  wire logic        zero_crossing_i,             // Event pulse, either edge
  input  wire logic        temp_conv_done_i,            // Event pulse
  input  wire logic        active_energy_overflow_i,    // Event pulse
  input  wire logic        voltage_peak_exceeded_i,     // Event pulse
  input  wire logic        current_peak_exceeded_i,     // Event pulse
  input  wire logic        apparent_energy_half_full_i, // Event pulse
  input  wire logic        apparent_energy_overflow_i,  // Event pulse
  input  wire logic        crossing_timeout_i,          // Event pulse
  input  wire logic        power_became_positive_i,     // Event pulse
  input  wire logic        power_became_negative_i,     // Event pulse
  output logic             irq_n_o,                     // Request pin output value (0)
  output logic             irq_oe_o,                    // Request pin drive enable
  output logic             sw_reset_o                   // Pulse while soft reset runs
);

  // ==========================================================================
  // Declarations
  mif_pkg::mif_state_t  state_reg;
  mif_pkg::mif_flags_t  enable_reg;
  mif_pkg::mif_flags_t  flags_reg;
  mif_pkg::mif_flags_t  flags_next;
  mif_pkg::mif_flags_t  event_vec;
  mif_pkg::mif_wb_req_t req;
  logic [1:0]           init_cnt_reg;
  logic                 access;
  logic                 acc_wr;
  logic                 acc_rd;
  logic                 reset_done;
  logic                 clear_all;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic                 swrst_req;
  logic                 swrst_q;

  // Word index decode, shared by read and write paths
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    return (adr[9:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  assign req.cyc = wb_cyc_i;
  assign req.stb = wb_stb_i;
  assign req.we  = wb_we_i;
  assign req.sel = wb_sel_i;
  assign req.adr = wb_adr_i[9:2];
  assign req.dat = wb_dat_i;

  // New request only when not already acknowledging, so each access acts once
  assign access = req.cyc && req.stb && !ack_reg && (state_reg != mif_pkg::MIF_ST_INIT);
  assign acc_wr = access && req.we;
  assign acc_rd = access && !req.we;

  // ==========================================================================
  // Event vector, one bit per flag
  always_comb begin
    event_vec = '0;
    event_vec[mif_pkg::MIF_BIT_ACTIVE_HALF]   = active_energy_half_full_i;
    event_vec[mif_pkg::MIF_BIT_DIP]           = line_voltage_dip_i;
    event_vec[mif_pkg::MIF_BIT_CYCLE_DONE]    = line_cycle_accum_done_i;
    event_vec[mif_pkg::MIF_BIT_SAMPLE_READY]  = waveform_sample_ready_i;
    event_vec[mif_pkg::MIF_BIT_ZERO_CROSS]    = zero_crossing_i;
    event_vec[mif_pkg::MIF_BIT_TEMP_DONE]     = temp_conv_done_i;
    event_vec[mif_pkg::MIF_BIT_RESET_DONE]    = reset_done;
    event_vec[mif_pkg::MIF_BIT_ACTIVE_OVF]    = active_energy_overflow_i;
    event_vec[mif_pkg::MIF_BIT_VPEAK]         = voltage_peak_exceeded_i;
    event_vec[mif_pkg::MIF_BIT_IPEAK]         = current_peak_exceeded_i;
    event_vec[mif_pkg::MIF_BIT_APPARENT_HALF] = apparent_energy_half_full_i;
    event_vec[mif_pkg::MIF_BIT_APPARENT_OVF]  = apparent_energy_overflow_i;
    event_vec[mif_pkg::MIF_BIT_CROSS_TIMEOUT] = crossing_timeout_i;
    event_vec[mif_pkg::MIF_BIT_POWER_POS]     = power_became_positive_i;
    event_vec[mif_pkg::MIF_BIT_POWER_NEG]     = power_became_negative_i;
  end

  // ==========================================================================
  // Reset sequencer: a software reset re-runs the init phase
  assign swrst_req = acc_wr && hit(wb_adr_i, mif_pkg::MIF_IDX_SW_RESET) && wb_sel_i[0]
                     && wb_dat_i[0];
  assign reset_done = (state_reg == mif_pkg::MIF_ST_INIT) && (init_cnt_reg == 2'h0);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= mif_pkg::MIF_ST_INIT;
      init_cnt_reg <= mif_pkg::MIF_INIT_CYCLES;
    end else begin
      case (state_reg)
        mif_pkg::MIF_ST_INIT: begin
          if (init_cnt_reg == 2'h0) begin
            state_reg <= mif_pkg::MIF_ST_RUN;
          end else begin
            init_cnt_reg <= init_cnt_reg - 2'h1;
          end
        end
        mif_pkg::MIF_ST_RUN: begin
          if (access) begin
            state_reg <= mif_pkg::MIF_ST_ACK;
          end
        end
        mif_pkg::MIF_ST_ACK: begin
          if (swrst_q) begin
            state_reg    <= mif_pkg::MIF_ST_INIT;
            init_cnt_reg <= mif_pkg::MIF_INIT_CYCLES;
          end else if (access) begin
            state_reg <= mif_pkg::MIF_ST_ACK;
          end else begin
            state_reg <= mif_pkg::MIF_ST_RUN;
          end
        end
        default: begin
          state_reg <= mif_pkg::MIF_ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      swrst_q    <= 1'b0;
      sw_reset_o <= 1'b0;
    end else begin
      swrst_q    <= swrst_req;
      sw_reset_o <= swrst_q || (state_reg == mif_pkg::MIF_ST_INIT);
    end
  end

  // ==========================================================================
  // Enable mask register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_reg <= mif_pkg::MIF_ENABLE_RST;
    end else if (swrst_q) begin
      enable_reg <= mif_pkg::MIF_ENABLE_RST;
    end else if (acc_wr && hit(wb_adr_i, mif_pkg::MIF_IDX_ENABLE)) begin
      if (wb_sel_i[0]) begin
        enable_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        enable_reg[15:8] <= wb_dat_i[15:8] & mif_pkg::MIF_IMPL_MASK[15:8];
      end
    end
  end

  // ==========================================================================
  // Status flags: a set in the clearing cycle wins
  assign clear_all = acc_rd && hit(wb_adr_i, mif_pkg::MIF_IDX_FLAGS_RC);

  always_comb begin
    flags_next = flags_reg;
    if (clear_all || swrst_q) begin
      flags_next = '0;
    end
    flags_next = (flags_next | event_vec) & mif_pkg::MIF_IMPL_MASK;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_reg <= mif_pkg::MIF_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // Interrupt pin; reset flag is masked off regardless of enable
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_oe_o <= 1'b0;
      irq_n_o  <= 1'b0;
    end else begin
      irq_oe_o <= |(flags_next & enable_reg & mif_pkg::MIF_IRQ_MASK);
      irq_n_o  <= 1'b0;
    end
  end

  // ==========================================================================
  // Bus answer: ack one cycle after the request, unmapped reads return zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= access;
      rdata_reg <= 32'h0000_0000;
      if (acc_rd) begin
        if (hit(wb_adr_i, mif_pkg::MIF_IDX_ENABLE)) begin
          rdata_reg <= {16'h0000, enable_reg};
        end else if (hit(wb_adr_i, mif_pkg::MIF_IDX_FLAGS) ||
                     hit(wb_adr_i, mif_pkg::MIF_IDX_FLAGS_RC)) begin
          rdata_reg <= {16'h0000, flags_reg & mif_pkg::MIF_IMPL_MASK};
        end
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

//--- sim/mif_properties.sv
// Purpose: Port-level checks of the metering interrupt flag block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Event-to-flag relations are judged by the bench
`timescale 1ns/1ps
module mif_chk (
  input wire logic        ref_clk_i,  // Clock
  input wire logic        rst_n_i,    // Reset, active low
  input wire logic        wb_cyc_i,   // Cycle
  input wire logic        wb_stb_i,   // Strobe
  input wire logic        wb_we_i,    // Write enable
  input wire logic [31:0] wb_dat_o,   // Read data
  input wire logic        wb_ack_o,   // Acknowledge
  input wire logic        irq_n_o,    // Pin value
  input wire logic        irq_oe_o,   // Pin enable
  input wire logic        sw_reset_o  // Init phase
);
  // ==========================================================================
  // Bus and pin checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !sw_reset_o;
  endsequence
  sequence s_answer;
    ##[1:4] wb_ack_o;
  endsequence
  chk_req_answered: assert property (s_take |-> s_answer)
    else $error("request left unanswered");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_bit15_zero: assert property (wb_ack_o && $past(!wb_we_i) |-> wb_dat_o[31:15] == 17'h0)
    else $error("reserved bits not zero");
  chk_pin_drive_low: assert property (irq_oe_o |-> !irq_n_o)
    else $error("request pin driven high");
  chk_init_no_irq: assert property (sw_reset_o [*2] |-> !irq_oe_o)
    else $error("request during init");
  chk_init_hold: assert property ($rose(sw_reset_o) |=> sw_reset_o)
    else $error("init phase too short");
endmodule
bind mif_top mif_chk i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .sw_reset_o(sw_reset_o));

//--- sim/mif_host.sv
// Purpose: Host microcontroller model, classic Wishbone master
// Assumes: Slave answers within 100 cycles
// Notes:   A used-up wait is counted in to_cnt for the bench
`timescale 1ns/1ps
module mif_host (
  input  wire logic        ref_clk_i,  // Clock
  input  wire logic        wb_ack_o,   // Slave acknowledge
  input  wire logic [31:0] wb_dat_o,   // Slave read data
  output logic             wb_cyc_i,   // Cycle
  output logic             wb_stb_i,   // Strobe
  output logic             wb_we_i,    // Write enable
  output logic [3:0]       wb_sel_i,   // Byte selects
  output logic [9:0]       wb_adr_i,   // Byte address
  output logic [31:0]      wb_dat_i    // Write data
);
  int to_cnt = 0;
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = '0;
  end
  task automatic xfer(input logic we, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, s, a, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    q = wb_dat_o;
    if (n >= 100) to_cnt++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Status first, so no cause is lost before the clearing read
  task automatic service(output logic [31:0] st, output logic [31:0] cl);
    xfer(1'b0, 10'h2c, 32'h0, 4'h3, st);
    xfer(1'b0, 10'h30, 32'h0, 4'h3, cl);
  endtask
endmodule

//--- sim/tb.sv
// Purpose: Self-checking bench of the metering interrupt flag block
// Assumes: Pin has a pull-up, so a released pin reads high
// Notes:   Event vector index skips status bit 6
`timescale 1ns/1ps
module tb;
  logic ref_clk_i, rst_n_i, ack, irq_n, irq_oe, sw_rst, cyc, stb, we;
  logic [13:0] ev;
  logic [3:0]  sel;
  logic [9:0]  adr;
  logic [31:0] dat_w, dat_r;
  int error_cnt = 0;
  int n_tests = 0;
  wire irq_pin = irq_oe ? irq_n : 1'b1;
  mif_top i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .active_energy_half_full_i(ev[0]), .line_voltage_dip_i(ev[1]),
    .line_cycle_accum_done_i(ev[2]), .waveform_sample_ready_i(ev[3]),
    .zero_crossing_i(ev[4]), .temp_conv_done_i(ev[5]), .active_energy_overflow_i(ev[6]),
    .voltage_peak_exceeded_i(ev[7]), .current_peak_exceeded_i(ev[8]),
    .apparent_energy_half_full_i(ev[9]), .apparent_energy_overflow_i(ev[10]),
    .crossing_timeout_i(ev[11]), .power_became_positive_i(ev[12]),
    .power_became_negative_i(ev[13]), .irq_n_o(irq_n), .irq_oe_o(irq_oe), .sw_reset_o(sw_rst));
  mif_host i_host (.ref_clk_i(ref_clk_i), .wb_ack_o(ack), .wb_dat_o(dat_r), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat_w));
  // ==========================================================================
  // Shared tasks
  task automatic end_sim();
    error_cnt += i_host.to_cnt;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, 4'h3, q);
    if (i_host.to_cnt != 0) end_sim();
    check(q, exp);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, s, q);
    if (i_host.to_cnt != 0) end_sim();
  endtask
  task automatic pin(input logic exp);
    repeat (2) @(posedge ref_clk_i);
    check({31'h0, irq_pin}, {31'h0, exp});
  endtask
  task automatic pulse(input int i);
    ev <= 14'h1 << i;
    @(posedge ref_clk_i);
    ev <= 14'h0;
    @(posedge ref_clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(10'h28, 32'h0);
    rd(10'h2c, 32'h40);
    pin(1'b1);
    rd(10'h30, 32'h40);
    rd(10'h2c, 32'h0);
  endtask
  task automatic t_events();
    logic [31:0] st, cl, exp;
    wr(10'h28, 32'h7fff, 4'h3);
    for (int i = 0; i < 14; i++) begin
      exp = 32'h1 << ((i < 6) ? i : i + 1);
      pulse(i);
      pin(1'b0);
      rd(10'h2c, exp);
      i_host.service(st, cl);
      check(st, exp);
      check(cl, exp);
      pin(1'b1);
    end
  endtask
  task automatic t_mask();
    wr(10'h40, 32'h1, 4'h1);
    repeat (6) @(posedge ref_clk_i);
    rd(10'h2c, 32'h40);
    rd(10'h28, 32'h0);
    wr(10'h28, 32'h40, 4'h3);
    pin(1'b1);
    pulse(0);
    pin(1'b1);
    rd(10'h2c, 32'h41);
    wr(10'h28, 32'h41, 4'h3);
    pin(1'b0);
    rd(10'h30, 32'h41);
    pin(1'b1);
  endtask
  task automatic t_bus();
    wr(10'h28, 32'h0, 4'h3);
    wr(10'h28, 32'hffff, 4'h1);
    rd(10'h28, 32'h00ff);
    wr(10'h28, 32'hffff, 4'h3);
    rd(10'h28, 32'h7fff);
    wr(10'h2c, 32'hffff, 4'h3);
    rd(10'h2c, 32'h0);
    rd(10'h3c, 32'h0);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    ev = 14'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    t_reset();
    t_events();
    t_mask();
    t_bus();
    end_sim();
  end
endmodule
